// ==== bct_pkg.sv ====
// Package of constants and carrier types for the buck channel trim, protection and dimming block.
package bct_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_FREQ_HZ = 50000000;
	localparam int DIM_DELAY_NS = 5500;
	// Longest time rounded down: 5500 ns at 20 ns gives 275 cycles.
	localparam int DIM_DELAY_CYC = (DIM_DELAY_NS / (1000000000 / CLK_FREQ_HZ)) > 0 ?
		(DIM_DELAY_NS / (1000000000 / CLK_FREQ_HZ)) : 1;
	localparam int ADC_CONV_NS = 8000;
	localparam int ADC_CONV_CYC = ADC_CONV_NS / (1000000000 / CLK_FREQ_HZ);

	// ************************************************************
	// Widths and reset values
	// ************************************************************
	localparam int TRIM_W = 7;
	localparam int VTHR_W = 8;
	localparam int OCCNT_W = 2;
	localparam int ADC_W = 8;
	localparam int RES_W = 9;
	localparam int SCALE_W = 16;
	localparam logic [TRIM_W-1:0] TRIM_NEUTRAL = 7'h3f;
	localparam int PAR_BIT = 8;
	localparam int NUM_CH = 2;
	localparam int NUM_ADC = 7;

	// ************************************************************
	// Converter channels
	// ************************************************************
	typedef enum logic [2:0] {
		BCT_AIN_BOOST = 3'h0,
		BCT_AIN_VDD = 3'h1,
		BCT_AIN_STR1_ON = 3'h2,
		BCT_AIN_STR2_ON = 3'h3,
		BCT_AIN_STR1 = 3'h4,
		BCT_AIN_STR2 = 3'h5,
		BCT_AIN_TEMP = 3'h6
	} bct_ain_t;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [TRIM_W-1:0] current_sense_trim;
		logic [VTHR_W-1:0] peak_threshold_code;
		logic [OCCNT_W-1:0] overcurrent_period_count;
		logic enable;
	} bct_ch_cfg_t;

	typedef struct packed {
		logic above_limit;
		logic period_tick;
	} bct_ch_sense_t;

endpackage

// ==== bct_dim_delay.sv ====
// Fixed phase delay line for one dimming control input.
`timescale 1ns/1ps
module bct_dim_delay #(
	parameter int DELAY = bct_pkg::DIM_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Dimming level in and delayed out
	input wire logic dim_in,
	output logic dim_out,
	// One-cycle pulse when the delayed level changes
	output logic edge_pulse
);
	import bct_pkg::*;

	localparam int CW = $clog2(DELAY + 1);

	logic [CW-1:0] cnt_r, cnt_nxt;
	logic pend_r, pend_nxt;
	logic out_r, out_nxt;
	logic edge_r, edge_nxt;

	// Both edges get the same count, so pulse width in equals pulse width out.
	// A second edge inside the window restarts nothing; input pulses shorter than
	// the delay come out stretched to DELAY + 1 cycles, a limitation the dimming source must respect.
	always_comb begin
		cnt_nxt = cnt_r;
		pend_nxt = pend_r;
		out_nxt = out_r;
		edge_nxt = 1'b0;
		if (!pend_r) begin
			if (dim_in != out_r) begin
				pend_nxt = 1'b1;
				cnt_nxt = CW'(DELAY - 1);
			end
		end else if (cnt_r == '0) begin
			pend_nxt = 1'b0;
			out_nxt = ~out_r;
			edge_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_r <= '0;
			pend_r <= 1'b0;
			out_r <= 1'b0;
			edge_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			pend_r <= pend_nxt;
			out_r <= out_nxt;
			edge_r <= edge_nxt;
		end
	end

	assign dim_out = out_r;
	assign edge_pulse = edge_r;
endmodule

// ==== bct_top.sv ====
// Trim, overcurrent latch-off, dimming delay and converter scan for two buck channels.
`timescale 1ns/1ps

module bct_top #(
	parameter int DELAY = bct_pkg::DIM_DELAY_CYC,
	parameter int CONV = bct_pkg::ADC_CONV_CYC,
	parameter logic [bct_pkg::TRIM_W-1:0] FACTORY_TRIM_1 = 7'h3f,
	parameter logic [bct_pkg::TRIM_W-1:0] FACTORY_TRIM_2 = 7'h3f
) (
	// Clock and reset, clock is the internal oscillator
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Host trim write, one channel per strobe
	input wire logic trim_wr,
	input wire logic trim_wr_ch,
	input wire logic [bct_pkg::TRIM_W-1:0] trim_wr_data,
	// Per-channel live configuration
	input wire logic [bct_pkg::VTHR_W-1:0] peak_threshold_code [bct_pkg::NUM_CH],
	input wire logic [bct_pkg::OCCNT_W-1:0] overcurrent_period_count [bct_pkg::NUM_CH],
	input wire logic [bct_pkg::NUM_CH-1:0] ch_enable,
	// Analog front end status
	input wire bct_pkg::bct_ch_sense_t ch_sense [bct_pkg::NUM_CH],
	// Dimming inputs
	input wire logic [bct_pkg::NUM_CH-1:0] dim_control_input,
	// Host flag read strobe per channel
	input wire logic [bct_pkg::NUM_CH-1:0] oc_flag_rd,
	// Converter interface
	input wire logic adc_done,
	input wire logic [bct_pkg::ADC_W-1:0] adc_code,
	output logic [2:0] adc_mux_sel,
	output logic adc_start,
	// Per-channel outputs
	output logic [bct_pkg::TRIM_W-1:0] current_sense_trim [bct_pkg::NUM_CH],
	output logic [bct_pkg::SCALE_W-1:0] peak_scale [bct_pkg::NUM_CH],
	output logic [bct_pkg::NUM_CH-1:0] buck_on,
	output logic [bct_pkg::NUM_CH-1:0] overcurrent_flag,
	// Converter results with parity
	output logic [bct_pkg::RES_W-1:0] adc_result [bct_pkg::NUM_ADC]
);
	import bct_pkg::*;

	// ************************************************************
	// Per-channel trim, scale, overcurrent and dimming
	// ************************************************************
	logic [NUM_CH-1:0] dly_lvl;
	logic [NUM_CH-1:0] dly_edge;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic [TRIM_W-1:0] trim_r, trim_nxt;
			logic [OCCNT_W:0] cnt_r, cnt_nxt;
			logic flag_r, flag_nxt;
			logic on_r, on_nxt;
			logic [SCALE_W-1:0] scale_r, scale_nxt;
			logic [TRIM_W-1:0] fac;
			logic [OCCNT_W:0] trip;

			assign fac = (g == 0) ? FACTORY_TRIM_1 : FACTORY_TRIM_2;
			assign trip = {1'b0, overcurrent_period_count[g]} + 1'b1;

			// Delays the dimming level before it gates the buck.
			bct_dim_delay #(.DELAY(DELAY)) u_dly (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.dim_in(dim_control_input[g]),
				.dim_out(dly_lvl[g]),
				.edge_pulse(dly_edge[g])
			);

			// Next state for trim, counter, flag, gate and scale factor.
			always_comb begin
				trim_nxt = trim_r;
				cnt_nxt = cnt_r;
				flag_nxt = flag_r;
				if (trim_wr && (trim_wr_ch == g[0])) begin
					trim_nxt = trim_wr_data;
				end
				// A read clears the latch; no trip can count in the same cycle, since counting below needs the flag clear.
				if (oc_flag_rd[g] && flag_r) begin
					flag_nxt = 1'b0;
					cnt_nxt = '0;
				end
				if (!ch_enable[g] || !ch_sense[g].above_limit || dly_edge[g]) begin
					cnt_nxt = '0;
				end else if (ch_sense[g].period_tick && !flag_r) begin
					cnt_nxt = cnt_r + 1'b1;
					if (cnt_nxt >= trip) begin
						flag_nxt = 1'b1;
						cnt_nxt = '0;
					end
				end
				// Buck follows the delayed dimming level unless disabled or latched off.
				on_nxt = ch_enable[g] && dly_lvl[g] && !flag_nxt;
				// Scale in Q2.14 units: 1.0 = 0x4000 of 2^14; 0.4*(t-63)/63.
				scale_nxt = SCALE_W'(32'sd16384 + ((32'sd6554 * ($signed({25'h0, trim_nxt})
					- 32'sd63)) / 32'sd63));
			end

			// State registers; the trim register itself takes the factory value on reset,
			// so no host write is needed before the first regulation cycle.
			// The scale starts at unity and follows the factory trim one edge later.
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					trim_r <= fac;
					cnt_r <= '0;
					flag_r <= 1'b0;
					on_r <= 1'b0;
					scale_r <= 16'h4000;
				end else begin
					trim_r <= trim_nxt;
					cnt_r <= cnt_nxt;
					flag_r <= flag_nxt;
					on_r <= on_nxt;
					scale_r <= scale_nxt;
				end
			end

			// Outputs come straight from the channel registers.
			assign current_sense_trim[g] = trim_r;
			assign peak_scale[g] = scale_r;
			assign buck_on[g] = on_r;
			assign overcurrent_flag[g] = flag_r;
		end
	endgenerate

	// ************************************************************
	// Converter sequencer
	// ************************************************************
	localparam int CCW = $clog2(CONV + 1);
	logic [2:0] sel_r, sel_nxt;
	logic start_r, start_nxt;
	logic [CCW-1:0] tmo_r, tmo_nxt;
	logic [RES_W-1:0] res_r [NUM_ADC];
	logic [RES_W-1:0] res_nxt [NUM_ADC];

	// Steps through every input on its own; results are written only on
	// completion so a read always sees the last finished value. A missing
	// done is covered by a timeout so the scan cannot stall.
	always_comb begin
		sel_nxt = sel_r;
		start_nxt = 1'b0;
		tmo_nxt = tmo_r;
		res_nxt = res_r;
		if (adc_done || tmo_r == '0) begin
			if (adc_done) begin
				res_nxt[sel_r] = {~^adc_code, adc_code};
			end
			sel_nxt = (sel_r == 3'(NUM_ADC - 1)) ? 3'h0 : sel_r + 3'h1;
			start_nxt = 1'b1;
			tmo_nxt = CCW'(CONV);
		end else begin
			tmo_nxt = tmo_r - 1'b1;
		end
	end

	// Sequencer registers.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_r <= 3'h0;
			start_r <= 1'b0;
			tmo_r <= '0;
			for (int i = 0; i < NUM_ADC; i++) begin
				res_r[i] <= 9'h100;
			end
		end else begin
			sel_r <= sel_nxt;
			start_r <= start_nxt;
			tmo_r <= tmo_nxt;
			res_r <= res_nxt;
		end
	end

	assign adc_mux_sel = sel_r;
	assign adc_start = start_r;
	assign adc_result = res_r;
endmodule

// ==== bct_adc_model.sv ====
// Behavioural converter front end that answers each conversion start.
`timescale 1ns/1ps
module bct_adc_model #(
	parameter int LAT = 5
) (
	// Clock
	input wire logic clk_sys,
	// Request
	input wire logic adc_start,
	input wire logic [2:0] adc_mux_sel,
	// Answer
	output logic adc_done,
	output logic [7:0] adc_code
);
	int cnt = 0;
	logic [2:0] sel_r = 3'h0;
	initial begin
		adc_done = 1'b0;
		adc_code = 8'h00;
	end
	// Outside the done pulse the code toggles, so a late capture of it is caught.
	always @(posedge clk_sys) begin
		adc_done <= 1'b0;
		adc_code <= ~adc_code;
		if (adc_start) begin
			cnt <= LAT;
			sel_r <= adc_mux_sel;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		if (!adc_start && cnt == 1) begin
			adc_done <= 1'b1;
			adc_code <= 8'h21 + {2'h0, sel_r, 3'h0};
		end
	end
endmodule

// ==== bct_top_monitor.sv ====
// Checker of overcurrent latch-off, dimming delay and converter storage.
`timescale 1ns/1ps
module bct_top_monitor #(
	parameter int DELAY = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Inputs
	input wire logic [1:0] ch_enable,
	input wire bct_pkg::bct_ch_sense_t ch_sense [2],
	input wire logic [1:0] dim_control_input,
	input wire logic [1:0] oc_flag_rd,
	input wire logic adc_done,
	input wire logic [7:0] adc_code,
	input wire logic [2:0] adc_mux_sel,
	// Outputs
	input wire logic [1:0] buck_on,
	input wire logic [1:0] overcurrent_flag,
	input wire logic [8:0] adc_result [7]
);
	import bct_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Eight cycles is longer than the whole delay path, so the output must have settled.
	sequence dim_on_s;
		(dim_control_input[0] && ch_enable[0] && !overcurrent_flag[0])[*8];
	endsequence
	sequence dim_off_s;
		(!dim_control_input[0])[*8];
	endsequence
	a_flag_hold: assert property (overcurrent_flag[0] && !oc_flag_rd[0] |=> overcurrent_flag[0])
		else $error("flag dropped without read");
	a_read_clears: assert property (overcurrent_flag[0] && oc_flag_rd[0] |=> !overcurrent_flag[0])
		else $error("flag kept after read");
	a_flag_cause: assert property ($rose(overcurrent_flag[0]) |->
		$past(ch_sense[0].above_limit && ch_sense[0].period_tick)) else $error("flag without tick");
	a_trip_off: assert property (overcurrent_flag[0] [*2] |-> !buck_on[0])
		else $error("buck on while tripped");
	a_dim_on: assert property (dim_on_s |-> buck_on[0])
		else $error("buck off with dim high");
	a_dim_off: assert property (dim_off_s |-> !buck_on[0])
		else $error("buck on with dim low");
	a_late_rise: assert property ($rose(buck_on[0]) |-> $past(dim_control_input[0], 3))
		else $error("buck rose too early");
	a_odd_parity: assert property ((^adc_result[0]) && (^adc_result[6]))
		else $error("result parity even");
	a_adc_store: assert property (adc_done && adc_mux_sel == 3'h6 |->
		##2 adc_result[6][7:0] == $past(adc_code, 2)) else $error("result not stored");
endmodule
bind bct_top bct_top_monitor #(.DELAY(DELAY)) u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.ch_enable(ch_enable), .ch_sense(ch_sense), .dim_control_input(dim_control_input),
	.oc_flag_rd(oc_flag_rd), .adc_done(adc_done), .adc_code(adc_code),
	.adc_mux_sel(adc_mux_sel), .buck_on(buck_on), .overcurrent_flag(overcurrent_flag),
	.adc_result(adc_result));

// ==== tb_bct_top.sv ====
// Testbench for the buck channel trim, protection and dimming block.
`timescale 1ns/1ps
module tb_bct_top;
	import bct_pkg::*;
	localparam int DLY = 4;
	typedef struct packed {
		logic ch;
		logic [6:0] trim;
	} bct_row_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic trim_wr = 1'b0;
	logic trim_wr_ch = 1'b0;
	logic [6:0] trim_wr_data = 7'h00;
	logic [7:0] thr [2] = '{8'h10, 8'h20};
	logic [1:0] occ [2] = '{2'h2, 2'h2};
	logic [1:0] ch_enable = 2'h3;
	bct_ch_sense_t sense [2] = '{2'h0, 2'h0};
	logic [1:0] dim = 2'h3;
	logic [1:0] rd = 2'h0;
	logic adc_done, adc_start;
	logic [7:0] adc_code;
	logic [2:0] sel;
	logic [6:0] trim [2];
	logic [15:0] scale [2];
	logic [1:0] buck_on, oc_flag;
	logic [8:0] res [7];
	int err_total = 0;
	int compares = 0;
	int n, m;
	real tj, kl;
	bct_row_t rows [4] = '{'{1'b0, 7'h3f}, '{1'b1, 7'h00}, '{1'b0, 7'h7e}, '{1'b1, 7'h50}};
	bct_top #(.DELAY(DLY), .CONV(8), .FACTORY_TRIM_1(7'h25), .FACTORY_TRIM_2(7'h5a)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .trim_wr(trim_wr), .trim_wr_ch(trim_wr_ch),
		.trim_wr_data(trim_wr_data), .peak_threshold_code(thr), .overcurrent_period_count(occ),
		.ch_enable(ch_enable), .ch_sense(sense), .dim_control_input(dim), .oc_flag_rd(rd),
		.adc_done(adc_done), .adc_code(adc_code), .adc_mux_sel(sel), .adc_start(adc_start),
		.current_sense_trim(trim), .peak_scale(scale), .buck_on(buck_on),
		.overcurrent_flag(oc_flag), .adc_result(res));
	bct_adc_model #(.LAT(5)) conv (.clk_sys(clk_sys), .adc_start(adc_start),
		.adc_mux_sel(sel), .adc_done(adc_done), .adc_code(adc_code));
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// Inputs always move 1 ns after the edge.
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic check_eq(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Ranges cover rounding the design may choose; an unknown never lands inside.
	task automatic check_rng(input string nm, input int lo, input int hi, input logic [15:0] got);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, got);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick0(input int k);
		repeat (k) begin
			sense[0].period_tick = 1'b1;
			cyc(1);
			sense[0].period_tick = 1'b0;
			cyc(2);
		end
	endtask
	task automatic wait_buck(input int ch, input logic lvl, output int k);
		k = 0;
		while (buck_on[ch] !== lvl) begin
			cyc(1);
			k++;
			if (k == 60) begin
				err_total++;
				finish_test();
			end
		end
	endtask
	function automatic logic [8:0] exp_res(input int i);
		logic [7:0] c;
		c = 8'h21 + 8'(i * 8);
		exp_res = {~^c, c};
	endfunction
	function automatic logic adc_ok();
		adc_ok = 1'b1;
		for (int i = 0; i < 7; i++) if (res[i] !== exp_res(i)) adc_ok = 1'b0;
	endfunction
	initial begin
		cyc(8);
		check_eq("result_rst", 16'h0100, {7'h0, res[0]});
		sys_rst = 1'b0;
		#1;
		check_eq("trim1_fact", 16'h0025, {9'h0, trim[0]});
		check_eq("trim2_fact", 16'h005a, {9'h0, trim[1]});
		cyc(2);
		foreach (rows[i]) begin
			trim_wr = 1'b1;
			trim_wr_ch = rows[i].ch;
			trim_wr_data = rows[i].trim;
			cyc(1);
			trim_wr = 1'b0;
			cyc(2);
			n = $rtoi(16384.0 * (1.0 + 0.4 * (rows[i].trim - 63.0) / 63.0));
			check_eq("trim", {9'h0, rows[i].trim}, {9'h0, trim[rows[i].ch]});
			check_rng("scale", n - 1, n + 1, scale[rows[i].ch]);
		end
		// Host trim for range 3: factory constant 0x25 plus signed delta -8.
		trim_wr = 1'b1;
		trim_wr_ch = 1'b0;
		trim_wr_data = 7'(7'h25 + {3'h7, 4'h8});
		cyc(1);
		trim_wr = 1'b0;
		cyc(2);
		check_eq("trim_r3", 16'h001d, {9'h0, trim[0]});
		// Temperature terms, scheme 1: reference 155 C, 200 C span, coefficient +2.
		tj = (40.0 - 50.5) / 0.805;
		kl = (2.0 - 2.18e-4 * 200.0 * 200.0) / -200.0;
		n = $rtoi(29.0 + kl * (tj - 155.0) + 2.18e-4 * (tj - 155.0) ** 2 + 0.5);
		trim_wr = 1'b1;
		trim_wr_data = 7'(n);
		cyc(1);
		trim_wr = 1'b0;
		cyc(2);
		check_eq("trim_tc", 16'h001e, {9'h0, trim[0]});
		// Count of 2 trips on the third period; below-limit and disable restart it.
		sense[0].above_limit = 1'b1;
		tick0(2);
		sense[0].above_limit = 1'b0;
		cyc(1);
		sense[0].above_limit = 1'b1;
		tick0(2);
		check_eq("flag_below", 16'h0, {15'h0, oc_flag[0]});
		ch_enable[0] = 1'b0;
		cyc(1);
		ch_enable[0] = 1'b1;
		tick0(2);
		check_eq("flag_dis", 16'h0, {15'h0, oc_flag[0]});
		tick0(1);
		check_eq("flag_trip", 16'h1, {15'h0, oc_flag[0]});
		tick0(2);
		cyc(10);
		check_eq("buck_trip", 16'h0, {15'h0, buck_on[0]});
		sense[0].above_limit = 1'b0;
		rd[0] = 1'b1;
		cyc(1);
		rd[0] = 1'b0;
		cyc(1);
		check_eq("flag_rd", 16'h0, {15'h0, oc_flag[0]});
		cyc(8);
		check_eq("buck_back", 16'h1, {15'h0, buck_on[0]});
		// A 20-cycle dimming pulse must come out delayed but just as wide.
		// Constant period, only the duty cycle is chosen by the host.
		dim[0] = 1'b0;
		cyc(12);
		dim[0] = 1'b1;
		wait_buck(0, 1'b1, n);
		check_rng("dim_lag", DLY, DLY + 3, 16'(n));
		cyc(20 - n);
		dim[0] = 1'b0;
		wait_buck(0, 1'b0, m);
		check_rng("dim_width", n, n, 16'(m));
		for (n = 0; n < 3000 && !adc_ok(); n++) cyc(1);
		for (int i = 0; i < 7; i++) check_eq("adc_result", {7'h0, exp_res(i)}, {7'h0, res[i]});
		finish_test();
	end
endmodule
